/* File: timer_consts.vh */
// register map, field positions, reset values and mode codes of the dual counter
`ifndef TIMER_CONSTS_VH
`define TIMER_CONSTS_VH

// register indices; byte address is four times the index
`define IDX_C0_VALUE    8'h0D
`define IDX_C0_CTRL     8'h0E
`define IDX_C1_HIGH     8'h0F
`define IDX_C1_LOW      8'h10
`define IDX_C1_CTRL     8'h11
`define IDX_STATUS      8'h12
`define IDX_OPTION      8'h13

// control register fields
`define CTRL_PSC_LSB    0
`define CTRL_EDGE_BIT   3
`define CTRL_RUN_BIT    4
`define CTRL_MODE_LSB   6
`define C0_CTRL_MASK    8'hDF
`define C1_CTRL_MASK    8'hD8
`define CTRL_RESET      8'h08

// status and option fields
`define STAT_C0_OVF_BIT 0
`define STAT_C1_OVF_BIT 1
`define OPT_C0_RTC_BIT  0
`define OPT_C1_RTC_BIT  1
`define OPT_RC_RTC_BIT  2
`define OPTION_RESET    8'h00

// operating modes
`define MODE_UNUSED     2'h0
`define MODE_EVENT      2'h1
`define MODE_TIMER      2'h2
`define MODE_PULSE      2'h3

// counter 1 internal base divider width in bits; it divides the system clock by two to this power, four
`define SYS_DIV_C1_BITS 2

`endif

/* File: time_base.v */
// internal clock sources and counter 0 prescaler
`timescale 1ns/1ps
`include "timer_consts.vh"

module time_base (
  // clock and reset
  input  wire       clk_sys_i,
  input  wire       sys_rst_i,
  // low frequency clock, sampled as a level
  input  wire       low_freq_clock_i,
  // static source choices
  input  wire       c0_use_rtc_i,
  input  wire       c1_use_rtc_i,
  input  wire [2:0] c0_prescale_i,
  // one-cycle count strobes
  output wire       c0_tick_o,
  output wire       c1_tick_o
);

  reg       rtc_q_ff;
  reg [7:0] psc_cnt_ff;
  reg [`SYS_DIV_C1_BITS-1:0] div4_cnt_ff;

  wire rtc_edge;
  wire c0_src;
  wire c1_src;

  // mask of low prescaler bits that must be ones for code n: divide by 2^(n+1)
  function [7:0] psc_mask;
    input [2:0] n;
    begin
      psc_mask = (8'h02 << n) - 8'h01;
    end
  endfunction

  assign rtc_edge = low_freq_clock_i & ~rtc_q_ff;
  assign c0_src   = c0_use_rtc_i ? rtc_edge : 1'b1;                  // see [RULE3]
  assign c1_src   = c1_use_rtc_i ? rtc_edge : (&div4_cnt_ff);         // see [RULE4]
  assign c0_tick_o = c0_src & ((psc_cnt_ff & psc_mask(c0_prescale_i)) == psc_mask(c0_prescale_i)); // see [RULE7] see [RULE19]
  assign c1_tick_o = c1_src;

  // free running dividers; prescaler only advances on the chosen source
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rtc_q_ff    <= 1'b0;
      psc_cnt_ff  <= 8'h00;
      div4_cnt_ff <= {`SYS_DIV_C1_BITS{1'b0}};
    end else begin
      rtc_q_ff    <= low_freq_clock_i;
      div4_cnt_ff <= div4_cnt_ff + 1'b1;
      if (c0_src) begin
        psc_cnt_ff <= psc_cnt_ff + 8'h01;
      end
    end
  end

endmodule // time_base

/* File: count_unit.v */
// one up-counter with preload, event, timer and pulse-width modes
`timescale 1ns/1ps
`include "timer_consts.vh"

module count_unit #(
  parameter W = 8
) (
  // clock and reset
  input  wire         clk_sys_i,
  input  wire         sys_rst_i,
  // count sources
  input  wire         tick_i,
  input  wire         pin_i,
  // control fields
  input  wire         edge_i,
  input  wire         run_i,
  input  wire [1:0]   mode_i,
  // preload write
  input  wire         wr_i,
  input  wire [W-1:0] wr_data_i,
  // state
  output wire [W-1:0] count_o,
  output reg          ovf_o,
  output reg          pulse_done_o
);

  localparam PW_WAIT = 1'b0;
  localparam PW_MEAS = 1'b1;

  reg [W-1:0] count_ff;
  reg [W-1:0] preload_ff;
  reg         pin_q_ff;
  reg         pw_state_ff;

  reg [W-1:0] nxt_count;
  reg         nxt_state;
  reg         step;
  reg         done;

  wire active_edge;
  wire at_start_level;

  assign count_o = count_ff;
  // 0 rising, 1 falling
  assign active_edge    = edge_i ? (pin_q_ff & ~pin_i) : (~pin_q_ff & pin_i); // see [RULE8] see [RULE9]
  assign at_start_level = edge_i ? pin_i : ~pin_i;

  // pick the count strobe for the mode and track a pulse measurement
  always @* begin
    step      = 1'b0;
    done      = 1'b0;
    nxt_state = pw_state_ff;
    case (mode_i) // see [RULE12]
      `MODE_EVENT: step = run_i & active_edge;
      `MODE_TIMER: step = run_i & tick_i;
      `MODE_PULSE: begin
        case (pw_state_ff)
          PW_WAIT: begin
            if (run_i && active_edge) begin
              nxt_state = PW_MEAS; // see [RULE16]
            end
          end
          PW_MEAS: begin
            if (!run_i) begin
              nxt_state = PW_WAIT;
            end else if (at_start_level) begin
              done      = 1'b1; // see [RULE16]
              nxt_state = PW_WAIT;
            end else begin
              step = tick_i;
            end
          end
          default: nxt_state = PW_WAIT;
        endcase
      end
      default: step = 1'b0; // see [RULE20]
    endcase
  end

  // count with reload on wrap; a write while stopped also loads the count
  always @* begin
    nxt_count = count_ff;
    if (wr_i && !run_i) begin
      nxt_count = wr_data_i; // see [RULE18]
    end else if (step) begin
      if (&count_ff) begin
        nxt_count = preload_ff; // see [RULE15]
      end else begin
        nxt_count = count_ff + 1'b1;
      end
    end
  end

  // overflow seen in the wrap cycle, so reload and flag land on one edge
  always @* begin
    ovf_o = step & (&count_ff) & ~(wr_i & ~run_i); // see [RULE15]
  end

  // chip reset stops everything; no other reset reaches these
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin // see [RULE14]
      count_ff     <= {W{1'b0}};
      preload_ff   <= {W{1'b0}};
      pin_q_ff     <= 1'b0;
      pw_state_ff  <= PW_WAIT;
      pulse_done_o <= 1'b0;
    end else begin
      count_ff     <= nxt_count;
      pin_q_ff     <= pin_i;
      pw_state_ff  <= nxt_state;
      pulse_done_o <= done;
      if (wr_i) begin
        preload_ff <= wr_data_i; // see [RULE18]
      end
    end
  end

endmodule // count_unit

/* File: dual_timer_event_counter.v */
// dual timer/event counter with ahb-lite register slave and buzzer output
// Operation
// [RULE1] counter 0 is 8-bit up-counter from pin, system clock or rtc clock
// [RULE2] counter 1 is 16-bit up-counter from pin, system clock over four or rtc
// [RULE3] static option picks counter 0 base: system clock or rtc if rc+rtc setup
// [RULE4] static option picks counter 1 base: sysclk/4 or rtc if rc+rtc setup
// [RULE5] buzzer output toggles on each counter 0 overflow
// [RULE6] counter 0 write sets preload, read returns live count
// [RULE7] counter 0 control bits 2:0 set prescale, code 011 divides by 16
// [RULE8] counter 0 control bit 3 picks pin edge, 0 rising, 1 falling
// [RULE9] counter 1 control bit 3 picks pin edge, 0 rising, 1 falling
// [RULE10] counter 0 control bit 4 enables counting
// [RULE11] counter 1 control bit 4 enables counting
// [RULE12] control bits 7:6 pick event, timer, pulse width or unused mode
// [RULE13] unused control bits read as zero
// [RULE14] chip reset stops counters and restores controls; warm reset leaves them
// [RULE15] event and timer modes wrap all ones to preload and set overflow flag
// [RULE16] pulse width counts between edges, then clears enable and keeps result
// [RULE17] counter 1 low byte buffered, high byte write moves both to preload
// [RULE18] write while stopped loads count too, while running only preload
// [RULE19] prescale code n divides by two to the power n plus one
// [RULE20] unused mode holds count and raises no overflow
`timescale 1ns/1ps
`include "timer_consts.vh"

module dual_timer_event_counter (
  // clock and reset
  input  wire        clk_sys_i,
  input  wire        sys_rst_i,
  // ahb-lite slave
  input  wire        hsel_i,
  input  wire [31:0] haddr_i,
  input  wire [1:0]  htrans_i,
  input  wire        hwrite_i,
  input  wire [2:0]  hsize_i,
  input  wire [31:0] hwdata_i,
  input  wire        hready_i,
  output reg  [31:0] hrdata_o,
  output reg         hreadyout_o,
  output reg         hresp_o,
  // counter pins and low frequency clock
  input  wire        counter0_pin_i,
  input  wire        counter1_pin_i,
  input  wire        low_freq_clock_i,
  // buzzer
  output reg         buzzer_frequency_out_o
);

  // registers
  reg  [7:0]  ctrl0_ff;
  reg  [7:0]  ctrl1_ff;
  reg  [7:0]  option_ff;
  reg  [1:0]  ovf_flag_ff;
  reg  [7:0]  lo_buf_ff;
  reg         wr_pend_ff;
  reg  [7:0]  wr_idx_ff;

  // bus decode
  wire        addr_phase;
  wire [7:0]  addr_idx;
  wire        rd_now;
  wire [7:0]  wdata;
  reg  [31:0] nxt_rdata;

  // write strobes applied in the data phase
  wire        wr_c0_val;
  wire        wr_c0_ctrl;
  wire        wr_c1_hi;
  wire        wr_c1_lo;
  wire        wr_c1_ctrl;
  wire        wr_status;
  wire        wr_option;

  // counter side
  wire        c0_tick;
  wire        c1_tick;
  wire [7:0]  c0_count;
  wire [15:0] c1_count;
  wire        c0_ovf;
  wire        c1_ovf;
  wire        c0_done;
  wire        c1_done;
  wire        rtc_ok;
  reg  [7:0]  nxt_ctrl0;
  reg  [7:0]  nxt_ctrl1;
  reg  [1:0]  nxt_flags;

  // register index from a byte address; word aligned
  function [7:0] reg_index;
    input [31:0] a;
    begin
      reg_index = (a[31:10] == 22'h000000) ? a[9:2] : 8'hFF;
    end
  endfunction

  // data-phase strobe for one register
  function wr_hit;
    input       pend;
    input [7:0] idx;
    input [7:0] want;
    begin
      wr_hit = pend & (idx == want);
    end
  endfunction

  assign addr_phase = hsel_i & htrans_i[1] & hready_i;
  assign addr_idx   = reg_index(haddr_i);
  assign rd_now     = addr_phase & ~hwrite_i;
  assign wdata      = hwdata_i[7:0];

  assign wr_c0_val  = wr_hit(wr_pend_ff, wr_idx_ff, `IDX_C0_VALUE);
  assign wr_c0_ctrl = wr_hit(wr_pend_ff, wr_idx_ff, `IDX_C0_CTRL);
  assign wr_c1_hi   = wr_hit(wr_pend_ff, wr_idx_ff, `IDX_C1_HIGH);
  assign wr_c1_lo   = wr_hit(wr_pend_ff, wr_idx_ff, `IDX_C1_LOW);
  assign wr_c1_ctrl = wr_hit(wr_pend_ff, wr_idx_ff, `IDX_C1_CTRL);
  assign wr_status  = wr_hit(wr_pend_ff, wr_idx_ff, `IDX_STATUS);
  assign wr_option  = wr_hit(wr_pend_ff, wr_idx_ff, `IDX_OPTION);

  // rtc base only exists in the rc+rtc oscillator setup
  assign rtc_ok = option_ff[`OPT_RC_RTC_BIT];

  // internal time bases and counter 0 prescaler
  time_base u_time_base (
    .clk_sys_i        (clk_sys_i),
    .sys_rst_i        (sys_rst_i),
    .low_freq_clock_i (low_freq_clock_i),
    .c0_use_rtc_i     (rtc_ok & option_ff[`OPT_C0_RTC_BIT]),  // see [RULE3]
    .c1_use_rtc_i     (rtc_ok & option_ff[`OPT_C1_RTC_BIT]),  // see [RULE4]
    .c0_prescale_i    (ctrl0_ff[`CTRL_PSC_LSB+2:`CTRL_PSC_LSB]),
    .c0_tick_o        (c0_tick),
    .c1_tick_o        (c1_tick)
  );

  // 8-bit counter 0
  count_unit #(.W(8)) u_counter0 (
    .clk_sys_i    (clk_sys_i),
    .sys_rst_i    (sys_rst_i),
    .tick_i       (c0_tick),                                    // see [RULE1]
    .pin_i        (counter0_pin_i),
    .edge_i       (ctrl0_ff[`CTRL_EDGE_BIT]),
    .run_i        (ctrl0_ff[`CTRL_RUN_BIT]),                    // see [RULE10]
    .mode_i       (ctrl0_ff[`CTRL_MODE_LSB+1:`CTRL_MODE_LSB]),
    .wr_i         (wr_c0_val),                                  // see [RULE6]
    .wr_data_i    (wdata),
    .count_o      (c0_count),
    .ovf_o        (c0_ovf),
    .pulse_done_o (c0_done)
  );

  // 16-bit counter 1; only the high byte write reaches it
  count_unit #(.W(16)) u_counter1 (
    .clk_sys_i    (clk_sys_i),
    .sys_rst_i    (sys_rst_i),
    .tick_i       (c1_tick),                                    // see [RULE2]
    .pin_i        (counter1_pin_i),
    .edge_i       (ctrl1_ff[`CTRL_EDGE_BIT]),
    .run_i        (ctrl1_ff[`CTRL_RUN_BIT]),                    // see [RULE11]
    .mode_i       (ctrl1_ff[`CTRL_MODE_LSB+1:`CTRL_MODE_LSB]),
    .wr_i         (wr_c1_hi),                                   // see [RULE17]
    .wr_data_i    ({wdata, lo_buf_ff}),                         // see [RULE17]
    .count_o      (c1_count),
    .ovf_o        (c1_ovf),
    .pulse_done_o (c1_done)
  );

  // control next values; software write beats the hardware run clear
  always @* begin
    nxt_ctrl0 = ctrl0_ff;
    nxt_ctrl1 = ctrl1_ff;
    if (c0_done) begin
      nxt_ctrl0[`CTRL_RUN_BIT] = 1'b0; // see [RULE16]
    end
    if (c1_done) begin
      nxt_ctrl1[`CTRL_RUN_BIT] = 1'b0; // see [RULE16]
    end
    if (wr_c0_ctrl) begin
      nxt_ctrl0 = wdata & `C0_CTRL_MASK; // see [RULE13]
    end
    if (wr_c1_ctrl) begin
      nxt_ctrl1 = wdata & `C1_CTRL_MASK; // see [RULE13]
    end
  end

  // overflow flags: write one to clear, a new overflow wins the same cycle
  always @* begin
    nxt_flags = ovf_flag_ff;
    if (wr_status) begin
      nxt_flags = ovf_flag_ff & ~wdata[1:0];
    end
    if (c0_ovf) begin
      nxt_flags[`STAT_C0_OVF_BIT] = 1'b1; // see [RULE15]
    end
    if (c1_ovf) begin
      nxt_flags[`STAT_C1_OVF_BIT] = 1'b1; // see [RULE15]
    end
  end

  // read mux, sampled in the address phase; unmapped reads give zero
  always @* begin
    nxt_rdata = 32'h00000000;
    case (addr_idx)
      `IDX_C0_VALUE: nxt_rdata[7:0] = c0_count;                 // see [RULE6]
      `IDX_C0_CTRL:  nxt_rdata[7:0] = ctrl0_ff & `C0_CTRL_MASK; // see [RULE13]
      `IDX_C1_HIGH:  nxt_rdata[7:0] = c1_count[15:8];
      `IDX_C1_LOW:   nxt_rdata[7:0] = lo_buf_ff;
      `IDX_C1_CTRL:  nxt_rdata[7:0] = ctrl1_ff & `C1_CTRL_MASK; // see [RULE13]
      `IDX_STATUS:   nxt_rdata[1:0] = ovf_flag_ff;
      `IDX_OPTION:   nxt_rdata[2:0] = option_ff[2:0];
      default:       nxt_rdata = 32'h00000000;
    endcase
  end

  // bus slave: zero wait states, always okay
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      hrdata_o    <= 32'h00000000;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      wr_pend_ff  <= 1'b0;
      wr_idx_ff   <= 8'h00;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      wr_pend_ff  <= addr_phase & hwrite_i;
      if (addr_phase) begin
        wr_idx_ff <= addr_idx;
      end
      if (rd_now) begin
        hrdata_o <= nxt_rdata;
      end
    end
  end

  // register state; only chip reset clears it
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin // see [RULE14]
      ctrl0_ff               <= `CTRL_RESET;
      ctrl1_ff               <= `CTRL_RESET;
      option_ff              <= `OPTION_RESET;
      ovf_flag_ff            <= 2'h0;
      lo_buf_ff              <= 8'h00;
      buzzer_frequency_out_o <= 1'b0;
    end else begin
      ctrl0_ff    <= nxt_ctrl0;
      ctrl1_ff    <= nxt_ctrl1;
      ovf_flag_ff <= nxt_flags;
      if (wr_option) begin
        option_ff <= wdata & 8'h07;
      end
      // high byte read snapshots low byte so the pair stays coherent
      if (rd_now && addr_idx == `IDX_C1_HIGH) begin
        lo_buf_ff <= c1_count[7:0];
      end else if (wr_c1_lo) begin
        lo_buf_ff <= wdata; // see [RULE17]
      end
      // toggle per overflow gives prescaled/(2*(256-N))
      if (c0_ovf) begin
        buzzer_frequency_out_o <= ~buzzer_frequency_out_o; // see [RULE5]
      end
    end
  end

endmodule // dual_timer_event_counter

/* File: dual_timer_event_counter_props.sv */
// port-level assertions for the dual counter slave and buzzer
`timescale 1ns/1ps
module dual_timer_event_counter_props (
  // clock and reset
  input wire        clk_sys_i,
  input wire        sys_rst_i,
  // bus
  input wire        hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0]  htrans_i,
  input wire        hwrite_i,
  input wire        hready_i,
  input wire [31:0] hrdata_o,
  input wire        hreadyout_o,
  input wire        hresp_o,
  // buzzer
  input wire        buzzer_frequency_out_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  // read address phase taken this edge
  wire rd = hsel_i & htrans_i[1] & hready_i & ~hwrite_i;

  property p_rdy; hreadyout_o; endproperty
  a_rdy: assert property (p_rdy) else $error("hreadyout low");
  property p_okay; !hresp_o; endproperty
  a_okay: assert property (p_okay) else $error("error response");
  property p_rst;
    disable iff (1'b0) sys_rst_i |=> hrdata_o == 32'h0 && hreadyout_o && !buzzer_frequency_out_o;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_c0b5; rd && haddr_i == 32'h38 |=> hrdata_o[5] == 1'b0; endproperty
  a_c0b5: assert property (p_c0b5) else $error("c0 bit5 set");
  property p_c1u; rd && haddr_i == 32'h44 |=> hrdata_o[5] == 1'b0 && hrdata_o[2:0] == 3'h0;
  endproperty
  a_c1u: assert property (p_c1u) else $error("c1 spare bits set");
  property p_c0w; rd && haddr_i == 32'h34 |=> hrdata_o[31:8] == 24'h0; endproperty
  a_c0w: assert property (p_c0w) else $error("c0 wider than 8");
  // counter 0 steps come at least two system cycles apart, so no back-to-back toggles
  property p_bz; $changed(buzzer_frequency_out_o) |=> $stable(buzzer_frequency_out_o);
  endproperty
  a_bz: assert property (p_bz) else $error("buzzer too fast");
  property p_hold; !rd |=> $stable(hrdata_o); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_none; rd && haddr_i == 32'h50 |=> hrdata_o == 32'h0; endproperty
  a_none: assert property (p_none) else $error("unmapped read nonzero");
  c_bz: cover property ($changed(buzzer_frequency_out_o));
  c_c1: cover property (rd && haddr_i == 32'h44);
  c_none: cover property (rd && haddr_i == 32'h50);
endmodule // dual_timer_event_counter_props

bind dual_timer_event_counter dual_timer_event_counter_props dual_timer_event_counter_props_inst (
  .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .buzzer_frequency_out_o(buzzer_frequency_out_o));

/* File: pin_source.sv */
// pulse burst model for a counter input pin
`timescale 1ns/1ps
module pin_source (
  // clock
  input  wire       clk_i,
  // burst request: pulse count, high and low widths
  input  wire       go_i,
  input  wire [7:0] num_i,
  input  wire [7:0] hi_i,
  input  wire [7:0] lo_i,
  // pin and status
  output reg        pin_o = 1'b0,
  output reg        busy_o = 1'b0
);
  reg [7:0] left_ff = 8'h0;
  reg [7:0] cnt_ff = 8'h0;
  // idle low between bursts, each burst ends low
  always @(posedge clk_i) begin
    if (go_i && !busy_o) begin
      busy_o <= 1'b1;
      left_ff <= num_i;
      pin_o <= 1'b1;
      cnt_ff <= hi_i;
    end else if (busy_o) begin
      if (cnt_ff > 8'h1) begin
        cnt_ff <= cnt_ff - 8'h1;
      end else if (pin_o) begin
        pin_o <= 1'b0;
        cnt_ff <= lo_i;
      end else if (left_ff > 8'h1) begin
        pin_o <= 1'b1;
        cnt_ff <= hi_i;
        left_ff <= left_ff - 8'h1;
      end else begin
        busy_o <= 1'b0;
      end
    end
  end
endmodule // pin_source

/* File: dual_timer_event_counter_tb_top.sv */
// self-checking bench for the dual timer/event counter
`timescale 1ns/1ps
module dual_timer_event_counter_tb_top;
  localparam A_C0V = 32'h34, A_C0C = 32'h38, A_C1H = 32'h3C, A_C1L = 32'h40;
  localparam A_C1C = 32'h44, A_ST = 32'h48, A_OPT = 32'h4C, A_NONE = 32'h50;
  reg         clk_sys_i = 1'b0;
  reg         sys_rst_i = 1'b1;
  reg         hsel = 1'b0;
  reg  [31:0] haddr = 32'h0;
  reg  [1:0]  htrans = 2'h0;
  reg         hwrite = 1'b0;
  reg  [31:0] hwdata = 32'h0;
  reg         lfc = 1'b0;
  reg  [1:0]  go = 2'h0;
  reg  [7:0]  num = 8'h0;
  reg  [7:0]  hi = 8'h0;
  reg  [7:0]  lo = 8'h0;
  reg  [31:0] q;
  wire [31:0] hrdata;
  wire        hready, hresp, bz, pin0, pin1, busy0, busy1;
  integer     failures = 0;
  integer     n_tests = 0;
  integer     cyc = 0;

  dual_timer_event_counter dual_timer_event_counter_inst (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .counter0_pin_i(pin0), .counter1_pin_i(pin1), .low_freq_clock_i(lfc),
    .buzzer_frequency_out_o(bz));
  pin_source pin0_inst (.clk_i(clk_sys_i), .go_i(go[0]), .num_i(num), .hi_i(hi),
    .lo_i(lo), .pin_o(pin0), .busy_o(busy0));
  pin_source pin1_inst (.clk_i(clk_sys_i), .go_i(go[1]), .num_i(num), .hi_i(hi),
    .lo_i(lo), .pin_o(pin1), .busy_o(busy1));

  // clock
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // slow clock of 20 cycles and hang guard
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc % 10 == 0) lfc <= ~lfc;
    if (cyc == 20000) begin
      failures = failures + 1;
      test_done;
    end
  end

  task test_done;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one single transfer; holds each phase until hready is seen high
  task bus(input w, input [31:0] a, input [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk_sys_i);
    while (hready !== 1'b1) @(posedge clk_sys_i);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_sys_i);
    while (hready !== 1'b1) @(posedge clk_sys_i);
    q = hrdata;
  endtask
  task rdc(input [31:0] a, input [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task waitc(input integer n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task burst(input integer i, input [7:0] n, input [7:0] h, input [7:0] l);
    num <= n;
    hi <= h;
    lo <= l;
    go[i] <= 1'b1;
    @(posedge clk_sys_i);
    go[i] <= 1'b0;
    @(posedge clk_sys_i);
    while (busy0 | busy1) @(posedge clk_sys_i);
  endtask
  task tog(input integer n, output integer t);
    reg last;
    t = 0;
    last = bz;
    repeat (n) begin
      @(posedge clk_sys_i);
      if (bz !== last) t = t + 1;
      last = bz;
    end
  endtask

  task t_reset;
    rdc(A_C0C, 32'h08);
    rdc(A_C1C, 32'h08);
    rdc(A_ST, 32'h0);
    $display("reset test done");
  endtask
  task t_bits;
    bus(1'b1, A_C0C, 32'h2F);
    rdc(A_C0C, 32'h0F);
    bus(1'b1, A_C1C, 32'h27);
    rdc(A_C1C, 32'h00);
    bus(1'b1, A_NONE, 32'hFF);
    rdc(A_NONE, 32'h0);
    bus(1'b1, A_C0C, 32'h00);
    // all ones, so any count in the unused mode would wrap at once
    bus(1'b1, A_C0V, 32'hFF);
    bus(1'b1, A_C0C, 32'h10);
    waitc(40);
    rdc(A_C0V, 32'hFF);
    rdc(A_ST, 32'h0);
    $display("bits test done");
  endtask
  // every prescale code over a window of eight expected counts
  task t_psc;
    integer n;
    for (n = 0; n < 8; n = n + 1) begin
      bus(1'b1, A_C0C, 32'h0);
      bus(1'b1, A_C0V, 32'h0);
      bus(1'b1, A_C0C, 32'h90 | n);
      waitc(8 << (n + 1));
      bus(1'b0, A_C0V, 32'h0);
      chk(q >= 7 && q <= 9, 1);
    end
    $display("prescale test done");
  endtask
  task t_ovf;
    integer t;
    bus(1'b1, A_C0C, 32'h0);
    bus(1'b1, A_C0V, 32'hFE);
    bus(1'b1, A_ST, 32'h3);
    bus(1'b1, A_C0C, 32'h90);
    tog(80, t);
    chk(t >= 19 && t <= 21, 1);
    rdc(A_ST, 32'h1);
    bus(1'b1, A_C0V, 32'hFC);
    waitc(16);
    tog(160, t);
    chk(t >= 19 && t <= 21, 1);
    bus(1'b1, A_C0C, 32'h0);
    $display("overflow test done");
  endtask
  task t_pulse;
    bus(1'b1, A_C0V, 32'h0);
    bus(1'b1, A_C0C, 32'hD0);
    burst(0, 8'd1, 8'd20, 8'd40);
    bus(1'b0, A_C0V, 32'h0);
    chk(q >= 9 && q <= 11, 1);
    rdc(A_C0C, 32'hC0);
    bus(1'b1, A_C0V, 32'h0);
    bus(1'b1, A_C0C, 32'hD8);
    burst(0, 8'd2, 8'd20, 8'd40);
    bus(1'b0, A_C0V, 32'h0);
    chk(q >= 19 && q <= 21, 1);
    rdc(A_C0C, 32'hC8);
    $display("pulse test done");
  endtask
  task t_c1;
    bus(1'b1, A_C1C, 32'h0);
    bus(1'b1, A_C1L, 32'h34);
    bus(1'b1, A_C1H, 32'h12);
    rdc(A_C1H, 32'h12);
    rdc(A_C1L, 32'h34);
    bus(1'b1, A_C1L, 32'hFE);
    bus(1'b1, A_C1H, 32'hFF);
    bus(1'b1, A_ST, 32'h3);
    bus(1'b1, A_C1C, 32'h50);
    burst(1, 8'd4, 8'd4, 8'd4);
    rdc(A_C1H, 32'hFF);
    rdc(A_C1L, 32'hFE);
    rdc(A_ST, 32'h2);
    bus(1'b1, A_C1C, 32'h0);
    bus(1'b1, A_C1L, 32'h0);
    bus(1'b1, A_C1H, 32'h0);
    bus(1'b1, A_C1C, 32'h90);
    waitc(80);
    rdc(A_C1H, 32'h0);
    // low byte was latched by the high read; fetch it from the buffer
    bus(1'b0, A_C1L, 32'h0);
    chk(q >= 19 && q <= 22, 1);
    bus(1'b1, A_C1C, 32'h0);
    $display("counter 1 test done");
  endtask
  task t_rtc;
    bus(1'b1, A_OPT, 32'h7);
    // counter 1 on the slow base too: one count per slow clock rise
    bus(1'b1, A_C1L, 32'h0);
    bus(1'b1, A_C1H, 32'h0);
    bus(1'b1, A_C1C, 32'h90);
    bus(1'b1, A_C0C, 32'h0);
    bus(1'b1, A_C0V, 32'h0);
    bus(1'b1, A_C0C, 32'h90);
    waitc(400);
    bus(1'b0, A_C0V, 32'h0);
    chk(q >= 9 && q <= 11, 1);
    rdc(A_C1H, 32'h0);
    bus(1'b0, A_C1L, 32'h0);
    chk(q >= 19 && q <= 22, 1);
    $display("slow clock test done");
  endtask

  // reset, then scenarios in turn
  initial begin
    repeat (20) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    t_reset;
    t_bits;
    t_psc;
    t_ovf;
    t_pulse;
    t_c1;
    t_rtc;
    test_done;
  end
endmodule // dual_timer_event_counter_tb_top
